/* ddb_burst_order.sv */
`timescale 1ns/1ns
module ddb_burst_order
   import ddb_pkg::*;
(
   input wire logic [2:0] start, // starting column low bits
   input wire logic [2:0] idx, // word index in the burst
   input wire logic len8, // burst of eight
   input wire logic ilv, // interleaved ordering
   output logic [2:0] word // column low bits of this word
);
   logic [1:0] lo_seq;
   always_comb begin
      lo_seq = start[1:0] + idx[1:0];
      if (ilv) begin
         word = len8 ? (start ^ idx) : {start[2], start[1:0] ^ idx[1:0]};
      end else if (len8) begin
         // nibble based: wrap in the starting half, then the other half
         word = {start[2] ^ idx[2], lo_seq};
      end else begin
         word = {start[2], lo_seq};
      end
   end
endmodule

/* ddb_ctl_model.sv */
`timescale 1ns/1ns
module ddb_ctl_model
   import ddb_pkg::*;
#(
   parameter int PRE_CYC = 3 // all bank precharge time in clocks
)(
   input wire logic clk, // system clock
   output logic cs_n, // chip select
   output logic ras_n, // row strobe
   output logic cas_n, // column strobe
   output logic we_n, // write enable
   output logic cke, // clock enable
   output logic [2:0] ba, // bank
   output logic [ROW_W-1:0] addr, // address pins
   output logic term // termination control
);
   initial begin
      {cs_n, ras_n, cas_n, we_n} = 4'hF;
      cke = 1'b1;
      ba = 3'h0;
      addr = '0;
      term = 1'b0;
   end
   // callers enter right after a rising edge and leave on one
   task automatic issue(input logic [3:0] c, input logic [2:0] b,
      input logic [ROW_W-1:0] a);
      {cs_n, ras_n, cas_n, we_n} <= c;
      ba <= b;
      addr <= a;
      @(posedge clk);
   endtask
   task automatic idle(input int n);
      {cs_n, ras_n, cas_n, we_n} <= 4'hF;
      repeat (n) @(posedge clk);
   endtask
   task automatic set_term(input logic v);
      term <= v;
      @(posedge clk);
   endtask
   // the two activates that follow this precharge keep every window below four
   task automatic pre_all();
      issue(CMD_PRE, 3'h0, 14'h0400);
      idle(PRE_CYC + 1);
   endtask
   // termination stays low and cke high past the update window
   task automatic mode(input logic [2:0] b, input logic [ROW_W-1:0] a);
      // one idle clock lets termination fall before the update starts
      term <= 1'b0;
      idle(1);
      issue(CMD_MODE, b, a);
      idle(3);
   endtask
   // callers space columns by a whole burst, so none is cut short
   task automatic col(input logic wr, input logic [2:0] b,
      input logic [COL_W-1:0] c);
      issue(wr ? CMD_WR : CMD_RD, b, {4'h0, c});
   endtask
   task automatic sref(input logic enter);
      cke <= !enter;
      issue(enter ? CMD_REF : 4'hF, 3'h0, '0);
   endtask
endmodule

/* ddb_dram_cmd.sv */
`timescale 1ns/1ns
module ddb_dram_cmd
   import ddb_pkg::*;
#(
   parameter int DRIVE_DELAY_NS = DRIVE_TEST_DELAY_NS,
   parameter int MOD_MIN_NS = MODE_UPDATE_MIN_NS,
   parameter int MOD_MAX_NS = MODE_UPDATE_MAX_NS
)(
   input wire logic SYS_CLK, // system clock
   input wire logic SYS_RST, // async reset, active high
   input wire logic PSEL, // apb select
   input wire logic PENABLE, // apb access phase
   input wire logic PWRITE, // apb direction
   input wire logic [11:0] PADDR, // apb byte address
   input wire logic [31:0] PWDATA, // apb write data
   output logic [31:0] PRDATA, // apb read data
   output logic PREADY, // apb ready
   output logic PSLVERR, // apb error on unmapped address
   input wire logic CS_N, // chip select
   input wire logic RAS_N, // row strobe
   input wire logic CAS_N, // column strobe
   input wire logic WE_N, // write enable
   input wire logic CKE, // clock enable
   input wire logic [2:0] BA, // bank select
   input wire logic [ROW_W-1:0] ADDR, // address pins
   input wire logic TERM_CTRL, // termination control pin
   output logic [2:0] TERM_SW, // termination switch enables
   output logic [15:0] TERM_DQ, // termination on data lines
   output logic [1:0] TERM_STROBE, // upper, lower strobe pairs
   output logic [1:0] TERM_MASK, // upper, lower write masks
   output logic DRV_OE, // drive test: all outputs driven
   output logic DRV_HIGH, // drive test level
   output logic ISSUE_VALID, // internal column issue
   output logic ISSUE_WRITE, // issued command is a write
   output logic ISSUE_AP, // issued with auto precharge
   output logic [2:0] ISSUE_BANK, // issued bank
   output logic [COL_W-1:0] ISSUE_COL, // issued start column
   output logic [ROW_W-1:0] ISSUE_ROW, // open row of issued bank
   output logic BURST_VALID, // burst word strobe
   output logic BURST_WRITE, // burst direction
   output logic [2:0] BURST_COL, // column low bits of word
   output logic [3:0] RD_LAT, // read latency in clocks
   output logic [3:0] WR_LAT // write latency in clocks
);
   function automatic int up_cyc(int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction
   function automatic int dn_cyc(int ns);
      int c;
      c = ns / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction
   function automatic logic [2:0] rtt_onehot(logic [1:0] r);
      return (r == 2'h0) ? 3'h0 : (3'h1 << (r - 2'h1));
   endfunction

   localparam int DRV_CYC = up_cyc(DRIVE_DELAY_NS);
   localparam int MOD_MIN_CYC = up_cyc(MOD_MIN_NS);
   localparam int MOD_MAX_CYC = dn_cyc(MOD_MAX_NS) < MOD_MIN_CYC ?
                                MOD_MIN_CYC : dn_cyc(MOD_MAX_NS);
   localparam int DRV_WIN = DRV_CYC + 1;
   localparam logic [CNT_W-1:0] DRV_CNT = CNT_W'(DRV_CYC);
   localparam logic [CNT_W-1:0] MOD_MIN = CNT_W'(MOD_MIN_CYC);
   localparam logic [CNT_W-1:0] MOD_MAX = CNT_W'(MOD_MAX_CYC);

   logic [3:0] cmd;
   logic is_act, is_col, is_pre, is_mr, is_emr1, is_sre, col_ok;
   logic [2:0] driver_calibration, bl_f, al_f;
   logic [1:0] rtt_f;
   assign cmd = {CS_N, RAS_N, CAS_N, WE_N};
   assign is_act = CKE && (cmd == CMD_ACT);
   assign is_col = CKE && ((cmd == CMD_RD) || (cmd == CMD_WR));
   assign is_pre = CKE && (cmd == CMD_PRE);
   assign is_mr = CKE && (cmd == CMD_MODE) && (BA == BA_MR);
   assign is_emr1 = CKE && (cmd == CMD_MODE) && (BA == BA_EMR1);
   assign is_sre = !CKE && (cmd == CMD_REF);
   assign driver_calibration = ADDR[EMR_OCD_LSB +: 3];
   assign bl_f = ADDR[MR_BL_LSB +: 3];
   assign al_f = ADDR[EMR_AL_LSB +: 3];
   assign rtt_f = {ADDR[EMR_RTT_HI], ADDR[EMR_RTT_LO]};

   // mode, termination and drive test state
   logic sr_r, sr_nxt, bl8_r, bl8_nxt, ilv_r, ilv_nxt;
   logic [2:0] cl_r, cl_nxt, al_r, al_nxt, tsw_r, tsw_nxt;
   logic [1:0] rtt_r, rtt_nxt, pend_r, pend_nxt;
   logic mod_busy_r, mod_busy_nxt, ton_r, ton_nxt;
   logic [CNT_W-1:0] mod_cnt_r, mod_cnt_nxt, drv_cnt_r, drv_cnt_nxt;
   logic drv_oe_r, drv_oe_nxt, drv_hi_r, drv_hi_nxt;
   logic drv_tgt_r, drv_tgt_nxt, drv_lvl_r, drv_lvl_nxt;
   logic [BANKS-1:0] open_r, open_nxt;
   logic [ROW_W-1:0] row_r [BANKS];
   logic [ROW_W-1:0] row_nxt [BANKS];
   logic [ERR_W-1:0] err_set;
   logic chk_r;

   always_comb begin
      sr_nxt = sr_r;
      bl8_nxt = bl8_r;
      ilv_nxt = ilv_r;
      cl_nxt = cl_r;
      al_nxt = al_r;
      rtt_nxt = rtt_r;
      pend_nxt = pend_r;
      mod_busy_nxt = mod_busy_r;
      mod_cnt_nxt = mod_cnt_r;
      drv_cnt_nxt = drv_cnt_r;
      drv_oe_nxt = drv_oe_r;
      drv_hi_nxt = drv_hi_r;
      drv_tgt_nxt = drv_tgt_r;
      drv_lvl_nxt = drv_lvl_r;
      open_nxt = open_r;
      row_nxt = row_r;
      err_set = '0;
      if (is_sre) begin
         sr_nxt = 1'b1;
      end else if (CKE) begin
         sr_nxt = 1'b0;
      end
      if (is_mr) begin
         if ((bl_f == BL_FOUR) || (bl_f == BL_EIGHT)) begin
            bl8_nxt = (bl_f == BL_EIGHT);
         end else begin
            err_set[ERR_BAD_MODE] = 1'b1;
         end
         ilv_nxt = ADDR[MR_BT_BIT];
         cl_nxt = ADDR[MR_CL_LSB +: 3];
      end
      if (mod_busy_r) begin
         mod_cnt_nxt = mod_cnt_r + 1'b1;
         if (mod_cnt_r == MOD_MIN) begin
            rtt_nxt = pend_r;
         end
         if (mod_cnt_r >= MOD_MAX) begin
            mod_busy_nxt = 1'b0;
         end
         if (!CKE) begin
            err_set[ERR_CKE_MOD] = 1'b1;
         end
      end
      if (drv_cnt_r != '0) begin
         drv_cnt_nxt = drv_cnt_r + 1'b1;
         if (drv_cnt_r == DRV_CNT) begin
            drv_oe_nxt = drv_tgt_r;
            drv_hi_nxt = drv_lvl_r;
            drv_cnt_nxt = '0;
         end
      end
      if (is_emr1) begin
         if (al_f <= 3'(AL_MAX)) begin
            al_nxt = al_f;
         end else begin
            err_set[ERR_BAD_MODE] = 1'b1;
         end
         if (rtt_f != (mod_busy_r ? pend_r : rtt_r)) begin
            pend_nxt = rtt_f;
            mod_busy_nxt = 1'b1;
            mod_cnt_nxt = CNT_W'(1);
         end
         if ((driver_calibration == OCD_DRIVE1) || (driver_calibration == OCD_DRIVE0) ||
             (driver_calibration == OCD_EXIT && (drv_oe_r || drv_tgt_r))) begin
            drv_tgt_nxt = (driver_calibration != OCD_EXIT);
            drv_lvl_nxt = (driver_calibration == OCD_DRIVE1);
            drv_cnt_nxt = CNT_W'(1);
         end
      end
      if (is_act) begin
         if (open_r[BA]) begin
            err_set[ERR_ACT_OPEN] = 1'b1;
         end
         open_nxt[BA] = 1'b1;
         row_nxt[BA] = ADDR;
      end
      if (is_col && !open_r[BA]) begin
         err_set[ERR_COL_CLOSED] = 1'b1;
      end
      if (is_col && ADDR[AP_BIT] && open_r[BA]) begin
         open_nxt[BA] = 1'b0;
      end
      if (is_pre) begin
         if (ADDR[AP_BIT]) begin
            open_nxt = '0;
         end else begin
            open_nxt[BA] = 1'b0;
         end
      end
      // termination is withheld in self refresh
      ton_nxt = TERM_CTRL && !sr_r && (rtt_r != 2'h0);
      tsw_nxt = (TERM_CTRL && !sr_r) ? rtt_onehot(rtt_r) : 3'h0;
   end

   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         sr_r <= 1'b0;
         bl8_r <= 1'b0;
         ilv_r <= 1'b0;
         cl_r <= CL_RST;
         al_r <= 3'h0;
         rtt_r <= 2'h0;
         pend_r <= 2'h0;
         mod_busy_r <= 1'b0;
         mod_cnt_r <= '0;
         drv_cnt_r <= '0;
         drv_oe_r <= 1'b0;
         drv_hi_r <= 1'b0;
         drv_tgt_r <= 1'b0;
         drv_lvl_r <= 1'b0;
         open_r <= '0;
         for (int i = 0; i < BANKS; i++) begin
            row_r[i] <= '0;
         end
         ton_r <= 1'b0;
         tsw_r <= 3'h0;
      end else begin
         sr_r <= sr_nxt;
         bl8_r <= bl8_nxt;
         ilv_r <= ilv_nxt;
         cl_r <= cl_nxt;
         al_r <= al_nxt;
         rtt_r <= rtt_nxt;
         pend_r <= pend_nxt;
         mod_busy_r <= mod_busy_nxt;
         mod_cnt_r <= mod_cnt_nxt;
         drv_cnt_r <= drv_cnt_nxt;
         drv_oe_r <= drv_oe_nxt;
         drv_hi_r <= drv_hi_nxt;
         drv_tgt_r <= drv_tgt_nxt;
         drv_lvl_r <= drv_lvl_nxt;
         open_r <= open_nxt;
         row_r <= row_nxt;
         ton_r <= ton_nxt;
         tsw_r <= tsw_nxt;
      end
   end

   assign TERM_SW = tsw_r;
   assign TERM_DQ = {16{ton_r}};
   assign TERM_STROBE = {2{ton_r}};
   assign TERM_MASK = {2{ton_r}};
   assign DRV_OE = drv_oe_r;
   assign DRV_HIGH = drv_hi_r;
   assign RD_LAT = {1'b0, al_r} + {1'b0, cl_r};
   assign WR_LAT = RD_LAT - 4'h1;

   // posted column pipe, one stage per clock of additive latency plus one
   logic [AL_MAX:0] pv_r, pv_nxt, pw_r, pw_nxt, pa_r, pa_nxt;
   logic [2:0] pb_r [AL_MAX+1];
   logic [2:0] pb_nxt [AL_MAX+1];
   logic [COL_W-1:0] pc_r [AL_MAX+1];
   logic [COL_W-1:0] pc_nxt [AL_MAX+1];
   logic bval_r, bval_nxt, bwr_r, bwr_nxt, blen8_r, blen8_nxt;
   logic bilv_r, bilv_nxt;
   logic [2:0] bidx_r, bidx_nxt, bst_r, bst_nxt, bcol_r, word;
   logic [2:0] ord_st, ord_idx;
   logic ord_len8, ord_ilv;

   // a closed bank is refused so that no stray data burst starts
   assign col_ok = is_col && open_r[BA];

   always_comb begin
      pv_nxt = {pv_r[AL_MAX-1:0], col_ok};
      pw_nxt = {pw_r[AL_MAX-1:0], (cmd == CMD_WR)};
      pa_nxt = {pa_r[AL_MAX-1:0], ADDR[AP_BIT]};
      pb_nxt[0] = BA;
      pc_nxt[0] = ADDR[COL_W-1:0];
      for (int i = 1; i <= AL_MAX; i++) begin
         pb_nxt[i] = pb_r[i-1];
         pc_nxt[i] = pc_r[i-1];
      end
      // a new issue restarts the burst: seamless or interrupting
      ord_st = ISSUE_VALID ? ISSUE_COL[2:0] : bst_r;
      ord_idx = ISSUE_VALID ? 3'h0 : bidx_r + 3'h1;
      ord_len8 = ISSUE_VALID ? bl8_r : blen8_r;
      ord_ilv = ISSUE_VALID ? ilv_r : bilv_r;
      bst_nxt = ord_st;
      bidx_nxt = ord_idx;
      blen8_nxt = ord_len8;
      bilv_nxt = ord_ilv;
      bwr_nxt = ISSUE_VALID ? ISSUE_WRITE : bwr_r;
      // nothing stops a burst early except the next issue
      bval_nxt = ISSUE_VALID ||
                 (bval_r && (bidx_r != (blen8_r ? 3'h7 : 3'h3)));
   end

   ddb_burst_order u_order (
      .start(ord_st),
      .idx(ord_idx),
      .len8(ord_len8),
      .ilv(ord_ilv),
      .word(word)
   );

   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         pv_r <= '0;
         pw_r <= '0;
         pa_r <= '0;
         for (int i = 0; i <= AL_MAX; i++) begin
            pb_r[i] <= 3'h0;
            pc_r[i] <= '0;
         end
         bval_r <= 1'b0;
         bwr_r <= 1'b0;
         blen8_r <= 1'b0;
         bilv_r <= 1'b0;
         bidx_r <= 3'h0;
         bst_r <= 3'h0;
         bcol_r <= 3'h0;
      end else begin
         pv_r <= pv_nxt;
         pw_r <= pw_nxt;
         pa_r <= pa_nxt;
         pb_r <= pb_nxt;
         pc_r <= pc_nxt;
         bval_r <= bval_nxt;
         bwr_r <= bwr_nxt;
         blen8_r <= blen8_nxt;
         bilv_r <= bilv_nxt;
         bidx_r <= bidx_nxt;
         bst_r <= bst_nxt;
         bcol_r <= word;
      end
   end

   assign ISSUE_VALID = pv_r[al_r];
   assign ISSUE_WRITE = pw_r[al_r];
   assign ISSUE_AP = pa_r[al_r];
   assign ISSUE_BANK = pb_r[al_r];
   assign ISSUE_COL = pc_r[al_r];
   assign ISSUE_ROW = row_r[pb_r[al_r]];
   assign BURST_VALID = bval_r;
   assign BURST_WRITE = bwr_r;
   assign BURST_COL = bcol_r;

   // apb slave, zero wait states
   logic [ERR_W-1:0] err_r, err_nxt;
   logic chk_nxt, wr_en, mapped;
   assign wr_en = PSEL && PENABLE && PWRITE;
   assign mapped = (PADDR == OFS_STATUS) || (PADDR == OFS_BANK) ||
                   (PADDR == OFS_ERR) || (PADDR == OFS_CTRL) ||
                   (PADDR == OFS_LAT);
   assign PREADY = 1'b1;
   assign PSLVERR = PSEL && PENABLE && !mapped;

   always_comb begin
      chk_nxt = chk_r;
      err_nxt = err_r;
      if (wr_en && (PADDR == OFS_CTRL)) begin
         chk_nxt = PWDATA[0];
      end
      if (wr_en && (PADDR == OFS_ERR)) begin
         err_nxt = err_r & ~PWDATA[ERR_W-1:0];
      end
      // a new error in the clearing cycle survives the clear
      err_nxt = err_nxt | (err_set & {ERR_W{chk_r}});
      unique case (PADDR)
         OFS_STATUS: PRDATA = {18'h0, mod_busy_r, drv_hi_r, drv_oe_r, sr_r,
                               rtt_r, al_r, cl_r, ilv_r, bl8_r};
         OFS_BANK: PRDATA = {24'h0, open_r};
         OFS_ERR: PRDATA = {28'h0, err_r};
         OFS_CTRL: PRDATA = {31'h0, chk_r};
         OFS_LAT: PRDATA = {24'h0, WR_LAT, RD_LAT};
         default: PRDATA = 32'h0;
      endcase
   end

   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         chk_r <= CTRL_CHECK_RST;
         err_r <= '0;
      end else begin
         chk_r <= chk_nxt;
         err_r <= err_nxt;
      end
   end

   property p_drive_on;
      @(posedge SYS_CLK) disable iff (SYS_RST)
      is_emr1 && ((driver_calibration == OCD_DRIVE1) || (driver_calibration == OCD_DRIVE0))
      |-> ##[1:DRV_WIN] DRV_OE;
   endproperty
   a_drive_on: assert property (p_drive_on)
      else $error("drive test outputs not enabled in time");
   property p_sr_term;
      @(posedge SYS_CLK) disable iff (SYS_RST)
      sr_r |=> (TERM_SW == 3'h0) && (TERM_DQ == 16'h0);
   endproperty
   a_sr_term: assert property (p_sr_term)
      else $error("termination active in self refresh");
   property p_one_sw;
      @(posedge SYS_CLK) disable iff (SYS_RST)
      TERM_CTRL && !sr_r && (rtt_r != 2'h0) |=> $onehot(TERM_SW);
   endproperty
   a_one_sw: assert property (p_one_sw)
      else $error("termination switch not exactly one");
   property p_x16;
      @(posedge SYS_CLK) disable iff (SYS_RST)
      TERM_CTRL && !sr_r && (rtt_r != 2'h0)
      |=> (TERM_DQ == 16'hFFFF) && (TERM_STROBE == 2'h3) &&
          (TERM_MASK == 2'h3);
   endproperty
   a_x16: assert property (p_x16)
      else $error("not all x16 lines terminated");
   property p_cke_mod;
      @(posedge SYS_CLK) disable iff (SYS_RST)
      mod_busy_r && !CKE && chk_r |=> err_r[ERR_CKE_MOD];
   endproperty
   a_cke_mod: assert property (p_cke_mod)
      else $error("cke low in update window not flagged");
   property p_act;
      @(posedge SYS_CLK) disable iff (SYS_RST)
      is_act |=> open_r[$past(BA)] && (row_r[$past(BA)] == $past(ADDR));
   endproperty
   a_act: assert property (p_act)
      else $error("activate did not open bank with row");
   property p_posted;
      @(posedge SYS_CLK) disable iff (SYS_RST)
      col_ok && (al_r == 3'h6) |-> ##7 ISSUE_VALID;
   endproperty
   a_posted: assert property (p_posted)
      else $error("posted command not issued after latency");
   property p_wl;
      @(posedge SYS_CLK) disable iff (SYS_RST)
      is_emr1 && (al_f == 3'h2) |=> (RD_LAT == cl_r + 4'h2) &&
                                    (WR_LAT == cl_r + 4'h1);
   endproperty
   a_wl: assert property (p_wl)
      else $error("latency sum wrong");
   property p_bl4;
      @(posedge SYS_CLK) disable iff (SYS_RST)
      ISSUE_VALID && !bl8_r ##1 !ISSUE_VALID [*4] |=> !BURST_VALID;
   endproperty
   a_bl4: assert property (p_bl4)
      else $error("burst of four wrong length");
   property p_first;
      @(posedge SYS_CLK) disable iff (SYS_RST)
      ISSUE_VALID |=> BURST_VALID && (BURST_COL == $past(ISSUE_COL[2:0]));
   endproperty
   a_first: assert property (p_first)
      else $error("burst does not start at start column");
endmodule

/* ddb_pkg.sv */
package ddb_pkg;
   localparam int CLK_PERIOD_NS = 100;
   localparam int DRIVE_TEST_DELAY_NS = 10;
   localparam int MODE_UPDATE_MIN_NS = 0;
   localparam int MODE_UPDATE_MAX_NS = 12;
   localparam int BANKS = 8;
   localparam int ROW_W = 14;
   localparam int COL_W = 10;
   localparam int AL_MAX = 6;
   localparam int CNT_W = 13;
   // {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0] CMD_MODE = 4'h0;
   localparam logic [3:0] CMD_REF = 4'h1;
   localparam logic [3:0] CMD_PRE = 4'h2;
   localparam logic [3:0] CMD_ACT = 4'h3;
   localparam logic [3:0] CMD_WR = 4'h4;
   localparam logic [3:0] CMD_RD = 4'h5;
   localparam logic [2:0] BA_MR = 3'h0;
   localparam logic [2:0] BA_EMR1 = 3'h1;
   localparam int MR_BL_LSB = 0;
   localparam int MR_BT_BIT = 3;
   localparam int MR_CL_LSB = 4;
   localparam logic [2:0] BL_FOUR = 3'h2;
   localparam logic [2:0] BL_EIGHT = 3'h3;
   localparam int EMR_RTT_LO = 2;
   localparam int EMR_RTT_HI = 6;
   localparam int EMR_AL_LSB = 3;
   localparam int EMR_OCD_LSB = 7;
   localparam logic [2:0] OCD_EXIT = 3'h0;
   localparam logic [2:0] OCD_DRIVE1 = 3'h1;
   localparam logic [2:0] OCD_DRIVE0 = 3'h2;
   localparam int AP_BIT = 10;
   localparam logic [2:0] CL_RST = 3'h5;
   localparam logic [11:0] OFS_STATUS = 12'h000;
   localparam logic [11:0] OFS_BANK = 12'h004;
   localparam logic [11:0] OFS_ERR = 12'h008;
   localparam logic [11:0] OFS_CTRL = 12'h00C;
   localparam logic [11:0] OFS_LAT = 12'h010;
   localparam int ERR_ACT_OPEN = 0;
   localparam int ERR_COL_CLOSED = 1;
   localparam int ERR_BAD_MODE = 2;
   localparam int ERR_CKE_MOD = 3;
   localparam int ERR_W = 4;
   localparam logic CTRL_CHECK_RST = 1'b1;
endpackage

/* test_ddr2_bank_access_burst_order.sv */
`timescale 1ns/1ns
module test_ddr2_bank_access_burst_order;
   import ddb_pkg::*;
   logic sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, d;
   logic cs_n, ras_n, cas_n, we_n, cke, term, drv_oe, drv_high;
   logic [2:0] ba, term_sw, issue_bank, burst_col;
   logic [ROW_W-1:0] addr, issue_row;
   logic [15:0] term_dq;
   logic [1:0] term_strobe, term_mask;
   logic issue_valid, issue_write, issue_ap, burst_valid, burst_write;
   logic [COL_W-1:0] issue_col;
   logic [3:0] rd_lat, wr_lat;
   int fails = 0;
   int cmp_count = 0;
   int cyc = 0;
   ddb_dram_cmd ddb_dram_cmd_inst (
      .SYS_CLK(sys_clk), .SYS_RST(sys_rst), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .CS_N(cs_n),
      .RAS_N(ras_n), .CAS_N(cas_n), .WE_N(we_n), .CKE(cke), .BA(ba),
      .ADDR(addr), .TERM_CTRL(term), .TERM_SW(term_sw), .TERM_DQ(term_dq),
      .TERM_STROBE(term_strobe), .TERM_MASK(term_mask), .DRV_OE(drv_oe),
      .DRV_HIGH(drv_high), .ISSUE_VALID(issue_valid),
      .ISSUE_WRITE(issue_write), .ISSUE_AP(issue_ap),
      .ISSUE_BANK(issue_bank), .ISSUE_COL(issue_col),
      .ISSUE_ROW(issue_row), .BURST_VALID(burst_valid),
      .BURST_WRITE(burst_write), .BURST_COL(burst_col), .RD_LAT(rd_lat),
      .WR_LAT(wr_lat));
   ddb_ctl_model ctl (.clk(sys_clk), .cs_n(cs_n), .ras_n(ras_n),
      .cas_n(cas_n), .we_n(we_n), .cke(cke), .ba(ba), .addr(addr),
      .term(term));
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   task automatic stop_test();
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 5000) begin
         fails++;
         stop_test();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   // release is followed by an edge so the next call never drives twice
   task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] wd, output logic [31:0] rd, output logic err);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) @(posedge sys_clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, '0, d, er);
      chk(d, e);
   endtask
   task automatic col_chk(input logic wr, input logic [2:0] b,
      input logic [COL_W-1:0] c, input int al, input logic l8,
      input logic il, input logic [ROW_W-1:0] row, input logic bv);
      logic [2:0] i;
      ctl.col(wr, b, c);
      ctl.idle(al);
      #1;
      chk({issue_valid, issue_write, issue_ap, issue_bank, issue_col,
         issue_row, burst_valid}, {1'b1, wr, 1'b0, b, c, row, bv});
      for (int n = 0; n < (l8 ? 8 : 4); n++) begin
         i = 3'(n);
         @(posedge sys_clk);
         #1;
         chk({burst_valid, burst_write, burst_col}, {1'b1, wr, il ? c[2:0]
            ^ i : {c[2] ^ i[2], c[1:0] + i[1:0]}});
      end
      @(posedge sys_clk);
      #1;
      chk(burst_valid, 32'h0);
      @(posedge sys_clk);
   endtask
   task automatic s_term();
      for (int r = 1; r < 4; r++) begin
         ctl.mode(BA_EMR1, 14'(((r & 2) << 5) | ((r & 1) << 2)));
         ctl.set_term(1'b1);
         repeat (2) @(posedge sys_clk);
         #1;
         chk(term_sw, 32'(1 << (r - 1)));
         chk({term_dq, term_strobe, term_mask}, 32'hFFFFF);
         @(posedge sys_clk);
      end
   endtask
   task automatic s_drive();
      for (int o = 1; o < 3; o++) begin
         ctl.mode(BA_EMR1, 14'(o << 7));
         #1;
         chk({drv_oe, drv_high}, {1'b1, o == 1});
         @(posedge sys_clk);
         ctl.mode(BA_EMR1, 14'h0);
         #1;
         chk(drv_oe, 32'h0);
         @(posedge sys_clk);
      end
   endtask
   task automatic s_sref();
      ctl.mode(BA_EMR1, 14'h4);
      ctl.set_term(1'b1);
      ctl.sref(1'b1);
      ctl.idle(2);
      #1;
      chk({term_sw, term_dq}, 32'h0);
      @(posedge sys_clk);
      ctl.sref(1'b0);
      ctl.idle(2);
      #1;
      chk(term_sw, 32'h1);
      @(posedge sys_clk);
   endtask
   task automatic s_burst();
      logic [1:0] n;
      ctl.pre_all();
      ctl.issue(CMD_ACT, 3'h3, 14'h1ABC);
      ctl.idle(1);
      rd(OFS_BANK, 32'h8);
      for (int m = 3; m >= 0; m--) begin
         n = 2'(m);
         ctl.mode(BA_MR, {7'h0, 3'h5, n[0], n[1] ? BL_EIGHT : BL_FOUR});
         col_chk(1'b0, 3'h3, 10'h5, 0, n[1], n[0], 14'h1ABC, 1'b0);
      end
      ctl.col(1'b0, 3'h3, 10'h0);
      ctl.idle(3);
      col_chk(1'b0, 3'h3, 10'h2, 0, 1'b0, 1'b0, 14'h1ABC, 1'b1);
      ctl.col(1'b0, 3'h6, 10'h0);
      ctl.idle(1);
      #1;
      chk(issue_valid, 32'h0);
      @(posedge sys_clk);
      rd(OFS_ERR, 32'h2);
      apb(1'b1, OFS_ERR, 32'h2, d, er);
      rd(OFS_ERR, 32'h0);
   endtask
   task automatic s_al();
      for (int a = 0; a < 7; a++) begin
         ctl.mode(BA_EMR1, 14'(a << 3));
         chk({wr_lat, rd_lat}, {4'(a + 4), 4'(a + 5)});
      end
      ctl.issue(CMD_ACT, 3'h2, 14'h2AAA);
      col_chk(1'b1, 3'h2, 10'h0A5, 6, 1'b0, 1'b0, 14'h2AAA, 1'b0);
   endtask
   task automatic s_cke();
      ctl.issue(CMD_MODE, BA_EMR1, 14'h4);
      ctl.sref(1'b1);
      ctl.sref(1'b0);
      ctl.idle(1);
      rd(OFS_ERR, 32'h8);
      apb(1'b1, OFS_ERR, 32'hF, d, er);
      apb(1'b1, OFS_CTRL, 32'h0, d, er);
      rd(OFS_CTRL, 32'h0);
      ctl.col(1'b0, 3'h6, 10'h0);
      ctl.idle(1);
      rd(OFS_ERR, 32'h0);
      apb(1'b1, OFS_CTRL, 32'h1, d, er);
      rd(OFS_CTRL, 32'h1);
   endtask
   initial begin
      sys_rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      repeat (10) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      #1;
      chk({rd_lat, wr_lat, term_sw, drv_oe}, 32'h540);
      @(posedge sys_clk);
      rd(OFS_LAT, 32'h45);
      rd(OFS_CTRL, 32'h1);
      apb(1'b0, 12'h020, '0, d, er);
      chk({er, d[30:0]}, 32'h80000000);
      s_term();
      s_drive();
      s_sref();
      s_burst();
      s_al();
      s_cke();
      stop_test();
   end
endmodule
